// [include/mso_pkg.sv]
// constants, register map and state codes of the system control outputs
// assumes a 40 MHz standby clock and a 32-bit Avalon-MM register slave
package mso_pkg;

	// ==========================================================
	// register map, word index; byte address is four times it
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_CMD = 3'h1;
	localparam logic [2:0] REG_CYCLE = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;

	// control register fields
	localparam int C_SUPPLY = 0;
	localparam int C_SMI = 1;
	localparam int C_SCI = 2;
	localparam int C_CLKDEF = 3;
	localparam int C_COOL = 4;
	localparam int C_PWRLED = 5;
	localparam int C_SPEAKER = 6;
	localparam int C_LOCKOUT = 7;
	localparam int C_FLOPPY = 8;
	localparam int C_VBLANK = 9;
	localparam int C_SMIWD = 10;
	localparam int C_PGKILL = 12;
	localparam int C_STOPCLK = 16;
	localparam logic [31:0] CTRL_MASK = 32'h000FF7FE;
	localparam logic [31:0] CTRL_RST = 32'h00000000;

	// command register bits, write one to act
	localparam int K_DIAG = 0;
	localparam int K_HRST = 1;
	localparam int K_CYCLE = 2;
	localparam int K_SMICLR = 3;

	// status register bits
	localparam int S_SUPPLY = 0;
	localparam int S_CYCLE = 1;
	localparam int S_DIAG = 2;
	localparam int S_HRST = 3;
	localparam int S_SECURE = 4;
	localparam int S_FPDIAG = 5;
	localparam int S_SMIWD = 6;
	localparam int S_PBTN = 7;
	localparam int S_RBTN = 8;

	// synchronised pin inputs
	localparam int P_FPDIAG = 0;
	localparam int P_PBTN = 1;
	localparam int P_RBTN = 2;
	localparam int P_SECURE = 3;
	localparam int P_WDOG = 4;
	localparam int NPIN = 5;

	// ==========================================================
	// timing: timers count 1 ms ticks
	localparam int CLK_HZ = 40000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = TICK_US * (CLK_HZ / 1000000);
	localparam int LEN_W = 16;
	localparam logic [15:0] DIAG_MS = 16'h000A;
	localparam logic [15:0] HRST_MS = 16'h0064;
	localparam logic [15:0] CYCLE_MS_RST = 16'h03E8;

	// ==========================================================
	// power state
	typedef enum logic [1:0] {
		PWR_OFF = 2'b00,
		PWR_ON = 2'b01,
		PWR_CYC = 2'b10
	} mso_pwr_e;

endpackage

// [include/mso_tmr_if.sv]
// handshake between the control block and one of its tick timers
// assumes both ends share the standby clock
`timescale 1ns/1ps
interface mso_tmr_if #(parameter int LEN_W = 16);
	logic start;
	logic [LEN_W-1:0] len;
	logic tick;
	logic busy;
	logic done;
	modport ctl(output start, output len, output tick,
		input busy, input done);
	modport tmr(input start, input len, input tick,
		output busy, output done);
endinterface

// [rtl/mso_timer.sv]
// one-shot timer counting tick enables
// assumes ticks are one-cycle pulses on the same clock
`timescale 1ns/1ps
module mso_timer #(parameter int LEN_W = 16) (
	input wire logic clk,
	input wire logic srst,
	mso_tmr_if.tmr t
);
	logic [LEN_W-1:0] cnt_r;
	logic busy_r;
	logic done_r;

	// a start while busy is dropped, so a running count is never stretched
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
		end else if (t.start && !busy_r) begin
			cnt_r <= (t.len == '0) ? LEN_W'(1) : t.len;
			busy_r <= 1'b1;
		end else if (busy_r && t.tick) begin
			cnt_r <= cnt_r - LEN_W'(1);
			if (cnt_r == LEN_W'(1)) begin
				busy_r <= 1'b0;
			end
		end
	end

	// one-cycle pulse as the count runs out
	always_ff @(posedge clk) begin
		if (srst) begin
			done_r <= 1'b0;
		end else begin
			done_r <= busy_r && t.tick && (cnt_r == LEN_W'(1));
		end
	end

	assign t.busy = busy_r;
	assign t.done = done_r;
endmodule

// [rtl/mso_ctrl.sv]
// system control output stage of the management controller
// assumes a standby-powered clock and an Avalon-MM master on the bus
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module mso_ctrl #(
	parameter int NCPU = 2,
	parameter int TICK_CYCLES = mso_pkg::TICK_CYC
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [2:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic FP_DIAG_IN,
	input wire logic PWR_BUTTON,
	input wire logic RST_BUTTON,
	input wire logic SECURE_MODE,
	input wire logic WDOG_EXPIRE,
	output logic DIAG_INTERRUPT_OUT,
	output logic SUPPLY_ON_REQUEST,
	output logic SMI_OUT,
	output logic SCI_OUT,
	output logic SYS_HRST_OUT,
	output logic [NCPU-1:0] CPU_PG_KILL,
	output logic [NCPU-1:0] CPU_STOPCLK,
	output logic CLKGEN_DEFAULT,
	output logic COOLING_ALARM_LED,
	output logic POWER_ALARM_LED,
	output logic SPEAKER,
	output logic FLOPPY_WP,
	output logic VIDEO_BLANK
);
	localparam int TW = $clog2(TICK_CYCLES + 1);

	// byte-lane merge for partial writes
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// tick divider
	logic [TW-1:0] div_r;
	logic tick_r;

	// one enable per millisecond keeps the timers on the single clock
	always_ff @(posedge CLK) begin
		if (SRST) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else if (div_r == TW'(TICK_CYCLES - 1)) begin
			div_r <= '0;
			tick_r <= 1'b1;
		end else begin
			div_r <= div_r + TW'(1);
			tick_r <= 1'b0;
		end
	end

	// ==========================================================
	// pin synchronisers
	logic [mso_pkg::NPIN-1:0] pin_a_r;
	logic [mso_pkg::NPIN-1:0] pin_s_r;
	logic [mso_pkg::NPIN-1:0] pin_d_r;
	logic [mso_pkg::NPIN-1:0] pins;
	logic [mso_pkg::NPIN-1:0] pin_rise;

	assign pins = {WDOG_EXPIRE, SECURE_MODE, RST_BUTTON, PWR_BUTTON,
		FP_DIAG_IN};

	// first stage feeds only the second; edges come from the second on
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pin_a_r <= '0;
			pin_s_r <= '0;
			pin_d_r <= '0;
		end else begin
			pin_a_r <= pins;
			pin_s_r <= pin_a_r;
			pin_d_r <= pin_s_r;
		end
	end

	assign pin_rise = pin_s_r & ~pin_d_r;

	// ==========================================================
	// Avalon-MM slave: one wait cycle on every access
	logic ack_r;
	logic [31:0] rdata_r;
	logic wr_go;
	logic ctrl_wr;
	logic cmd_wr;
	logic cyc_wr;

	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
	assign wr_go = AVS_WRITE & ack_r;
	assign ctrl_wr = wr_go && (AVS_ADDRESS == mso_pkg::REG_CTRL);
	assign cmd_wr = wr_go && (AVS_ADDRESS == mso_pkg::REG_CMD);
	assign cyc_wr = wr_go && (AVS_ADDRESS == mso_pkg::REG_CYCLE);

	// ack drops at the accepting edge so a held request is taken once
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (AVS_READ | AVS_WRITE) & ~ack_r;
		end
	end

	// ==========================================================
	// control and configuration registers
	logic [31:0] ctrl_r;
	logic [mso_pkg::LEN_W-1:0] cyc_len_r;
	logic fp_block;
	logic [3:0] cmd;

	// supply bit is held by the power state, not stored here
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ctrl_r <= mso_pkg::CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_r <= be_merge(ctrl_r, AVS_WRITEDATA, AVS_BYTEENABLE)
				& mso_pkg::CTRL_MASK;
		end
	end

	logic [31:0] cyc_merge;
	assign cyc_merge = be_merge({16'h0000, cyc_len_r}, AVS_WRITEDATA,
		AVS_BYTEENABLE);
	// off time of a power cycle, in ms; reset value stands in for nvram
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cyc_len_r <= mso_pkg::CYCLE_MS_RST;
		end else if (cyc_wr) begin
			cyc_len_r <= cyc_merge[mso_pkg::LEN_W-1:0];
		end
	end

	assign cmd = cmd_wr && AVS_BYTEENABLE[0] ? AVS_WRITEDATA[3:0] : 4'h0;
	// buttons lose their power-down and reset power
	assign fp_block = ctrl_r[mso_pkg::C_LOCKOUT] | pin_s_r[mso_pkg::P_SECURE];

	// ==========================================================
	// timers
	mso_tmr_if #(.LEN_W(mso_pkg::LEN_W)) t_diag();
	mso_tmr_if #(.LEN_W(mso_pkg::LEN_W)) t_hrst();
	mso_tmr_if #(.LEN_W(mso_pkg::LEN_W)) t_cyc();

	mso_timer #(.LEN_W(mso_pkg::LEN_W)) u_diag (
		.clk(CLK),
		.srst(SRST),
		.t(t_diag)
	);
	mso_timer #(.LEN_W(mso_pkg::LEN_W)) u_hrst (
		.clk(CLK),
		.srst(SRST),
		.t(t_hrst)
	);
	mso_timer #(.LEN_W(mso_pkg::LEN_W)) u_cyc (
		.clk(CLK),
		.srst(SRST),
		.t(t_cyc)
	);

	logic cyc_go;
	logic hrst_go;

	assign t_diag.tick = tick_r;
	assign t_hrst.tick = tick_r;
	assign t_cyc.tick = tick_r;
	assign t_diag.len = mso_pkg::DIAG_MS;
	assign t_hrst.len = mso_pkg::HRST_MS;
	assign t_cyc.len = cyc_len_r;
	assign t_diag.start = cmd[mso_pkg::K_DIAG];
	// firmware or an unlocked reset button starts the reset pulse
	assign hrst_go = cmd[mso_pkg::K_HRST] |
		(pin_rise[mso_pkg::P_RBTN] & ~fp_block);
	assign t_hrst.start = hrst_go;
	assign t_cyc.start = cyc_go;

	// ==========================================================
	// power state machine
	mso_pkg::mso_pwr_e pwr_r;
	mso_pkg::mso_pwr_e pwr_nxt;
	logic sup_wr;
	logic sup_val;
	logic pbtn_go;

	// supply request rides in bit zero of a control write
	assign sup_wr = ctrl_wr & AVS_BYTEENABLE[0];
	assign sup_val = AVS_WRITEDATA[mso_pkg::C_SUPPLY];
	// the button may always power up, but powers down only unlocked
	assign pbtn_go = pin_rise[mso_pkg::P_PBTN] &
		((pwr_r == mso_pkg::PWR_OFF) | ~fp_block);
	// cycles start only from on, so a repeat during the count is lost
	assign cyc_go = cmd[mso_pkg::K_CYCLE] &
		(pwr_r == mso_pkg::PWR_ON);

	// nothing but this state moves the supply request
	always_comb begin
		pwr_nxt = pwr_r;
		case (pwr_r)
			mso_pkg::PWR_OFF: begin
				if ((sup_wr & sup_val) | pbtn_go) begin
					pwr_nxt = mso_pkg::PWR_ON;
				end
			end
			mso_pkg::PWR_ON: begin
				if (cyc_go) begin
					pwr_nxt = mso_pkg::PWR_CYC;
				end else if ((sup_wr & ~sup_val) | pbtn_go) begin
					pwr_nxt = mso_pkg::PWR_OFF;
				end
			end
			mso_pkg::PWR_CYC: begin
				if (t_cyc.done) begin
					pwr_nxt = mso_pkg::PWR_ON;
				end
			end
			default: begin
				pwr_nxt = mso_pkg::PWR_OFF;
			end
		endcase
	end

	// only SRST clears state; the hard reset we drive never loops back
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pwr_r <= mso_pkg::PWR_OFF;
		end else begin
			pwr_r <= pwr_nxt;
		end
	end

	// ==========================================================
	// watchdog smi latch
	logic smi_wd_r;
	logic wd_hit;

	assign wd_hit = pin_rise[mso_pkg::P_WDOG] & ctrl_r[mso_pkg::C_SMIWD];
	// a set beats a clear in the same cycle so no expiry is lost
	always_ff @(posedge CLK) begin
		if (SRST) begin
			smi_wd_r <= 1'b0;
		end else if (wd_hit) begin
			smi_wd_r <= 1'b1;
		end else if (cmd[mso_pkg::K_SMICLR]) begin
			smi_wd_r <= 1'b0;
		end
	end

	// ==========================================================
	// board outputs
	// every pin leaves a flip-flop so no decode glitch reaches the board
	always_ff @(posedge CLK) begin
		if (SRST) begin
			DIAG_INTERRUPT_OUT <= 1'b0;
			SUPPLY_ON_REQUEST <= 1'b0;
			SMI_OUT <= 1'b0;
			SCI_OUT <= 1'b0;
			SYS_HRST_OUT <= 1'b0;
			CPU_PG_KILL <= '0;
			CPU_STOPCLK <= '0;
			CLKGEN_DEFAULT <= 1'b0;
			COOLING_ALARM_LED <= 1'b0;
			POWER_ALARM_LED <= 1'b0;
			SPEAKER <= 1'b0;
			FLOPPY_WP <= 1'b0;
			VIDEO_BLANK <= 1'b0;
		end else begin
			DIAG_INTERRUPT_OUT <= pin_s_r[mso_pkg::P_FPDIAG] |
				t_diag.busy;
			SUPPLY_ON_REQUEST <= (pwr_r == mso_pkg::PWR_ON);
			SMI_OUT <= ctrl_r[mso_pkg::C_SMI] | smi_wd_r;
			SCI_OUT <= ctrl_r[mso_pkg::C_SCI];
			SYS_HRST_OUT <= t_hrst.busy;
			CPU_PG_KILL <= ctrl_r[mso_pkg::C_PGKILL +: NCPU];
			CPU_STOPCLK <= ctrl_r[mso_pkg::C_STOPCLK +: NCPU];
			CLKGEN_DEFAULT <= ctrl_r[mso_pkg::C_CLKDEF];
			COOLING_ALARM_LED <= ctrl_r[mso_pkg::C_COOL];
			// no tie to the power state, so it works on standby too
			POWER_ALARM_LED <= ctrl_r[mso_pkg::C_PWRLED];
			SPEAKER <= ctrl_r[mso_pkg::C_SPEAKER];
			FLOPPY_WP <= ctrl_r[mso_pkg::C_FLOPPY];
			VIDEO_BLANK <= ctrl_r[mso_pkg::C_VBLANK];
		end
	end

	// ==========================================================
	// register read path
	logic [31:0] rd_mux;

	// status is a live snapshot, except the watchdog smi bit, which stays latched until software clears it
	always_comb begin
		rd_mux = '0;
		case (AVS_ADDRESS)
			mso_pkg::REG_CTRL: begin
				rd_mux = ctrl_r;
				rd_mux[mso_pkg::C_SUPPLY] = (pwr_r == mso_pkg::PWR_ON);
			end
			mso_pkg::REG_CYCLE: begin
				rd_mux[mso_pkg::LEN_W-1:0] = cyc_len_r;
			end
			mso_pkg::REG_STATUS: begin
				rd_mux[mso_pkg::S_SUPPLY] = (pwr_r == mso_pkg::PWR_ON);
				rd_mux[mso_pkg::S_CYCLE] = (pwr_r == mso_pkg::PWR_CYC);
				rd_mux[mso_pkg::S_DIAG] = t_diag.busy;
				rd_mux[mso_pkg::S_HRST] = t_hrst.busy;
				rd_mux[mso_pkg::S_SECURE] = pin_s_r[mso_pkg::P_SECURE];
				rd_mux[mso_pkg::S_FPDIAG] = pin_s_r[mso_pkg::P_FPDIAG];
				rd_mux[mso_pkg::S_SMIWD] = smi_wd_r;
				rd_mux[mso_pkg::S_PBTN] = pin_s_r[mso_pkg::P_PBTN];
				rd_mux[mso_pkg::S_RBTN] = pin_s_r[mso_pkg::P_RBTN];
			end
			default: rd_mux = '0;
		endcase
	end

	// captured in the wait cycle, so it stands at the accepting edge
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rdata_r <= '0;
		end else if (AVS_READ & ~ack_r) begin
			rdata_r <= rd_mux;
		end
	end

	assign AVS_READDATA = rdata_r;

	// ==========================================================
	// assertions
	AST_DIAG_PANEL: assert property (@(posedge CLK)
		disable iff (SRST) pin_s_r[mso_pkg::P_FPDIAG] |=> DIAG_INTERRUPT_OUT)
		else $error("panel diagnostic input not passed on");
	AST_DIAG_PULSE: assert property (@(posedge CLK)
		disable iff (SRST)
		cmd[mso_pkg::K_DIAG] && !t_diag.busy |-> ##2 DIAG_INTERRUPT_OUT)
		else $error("diagnostic pulse command not driven");
	AST_SUPPLY_STATE: assert property (@(posedge CLK)
		disable iff (SRST)
		SUPPLY_ON_REQUEST == $past(pwr_r == mso_pkg::PWR_ON))
		else $error("supply request differs from power state");
	AST_CYCLE_OFF: assert property (@(posedge CLK)
		disable iff (SRST) pwr_r == mso_pkg::PWR_CYC |=> !SUPPLY_ON_REQUEST)
		else $error("supply request high during power cycle");
	AST_SECURE_HOLD: assert property (@(posedge CLK)
		disable iff (SRST) pin_s_r[mso_pkg::P_SECURE] && pbtn_go
		&& pwr_r == mso_pkg::PWR_ON && !cyc_go && !sup_wr
		|=> pwr_r == mso_pkg::PWR_ON)
		else $error("power button powered down in secure mode");
	AST_RESET_LOCKED: assert property (@(posedge CLK)
		disable iff (SRST) fp_block && pin_rise[mso_pkg::P_RBTN]
		&& !cmd[mso_pkg::K_HRST] && !t_hrst.busy |=> !t_hrst.busy)
		else $error("reset button acted while locked");
	AST_SMI_WDOG: assert property (@(posedge CLK)
		disable iff (SRST) wd_hit |-> ##2 SMI_OUT)
		else $error("watchdog expiry raised no smi");
	AST_HRST_CMD: assert property (@(posedge CLK)
		disable iff (SRST)
		cmd[mso_pkg::K_HRST] && !t_hrst.busy |-> ##2 SYS_HRST_OUT)
		else $error("hard reset command not driven");
endmodule

// [sim/mso_panel_model.sv]
// front panel and keyboard controller stand-in for the control outputs
// assumes the bench calls set_pin just after a rising clock edge
`timescale 1ns/1ps
module mso_panel_model (
	input wire logic clk,
	input wire logic smi,
	output logic [4:0] pins
);
	int smi_seen;
	// ==========================================================
	// panel pins start released; buttons idle low
	initial pins = 5'h00;
	// the host handler is in place before any smi; every clock with smi high adds one to the count
	always @(posedge clk) begin
		if (smi) smi_seen <= smi_seen + 1;
	end
	task set_pin(input int i, input logic v);
		pins[i] <= v;
	endtask
endmodule

// [sim/mso_ctrl_test.sv]
// bench for the system control outputs, registers over Avalon-MM
// assumes the panel model drives the front-panel and keyboard inputs
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module mso_ctrl_test;
	localparam int T = 8;
	logic CLK = 0, SRST = 1, rd_w = 0, wr_w = 0;
	logic [2:0] adr = 3'h0;
	logic [31:0] wd = 32'h0, q, rdd;
	logic wq, dg, sup, smi, hr, sc, cd, co, pl, sp, fw, vb;
	logic [1:0] pg, st;
	logic [4:0] pins;
	int n_mismatch = 0, checked = 0, n, i;
	int fb[12];
	always #12.5 CLK = ~CLK;
	mso_panel_model pm (.clk(CLK), .smi(smi), .pins(pins));
	// short ticks keep the millisecond timers within the run length
	mso_ctrl #(.NCPU(2), .TICK_CYCLES(T)) uut (.CLK(CLK), .SRST(SRST),
		.AVS_ADDRESS(adr), .AVS_READ(rd_w), .AVS_WRITE(wr_w),
		.AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdd),
		.AVS_WAITREQUEST(wq), .FP_DIAG_IN(pins[mso_pkg::P_FPDIAG]),
		.PWR_BUTTON(pins[mso_pkg::P_PBTN]), .RST_BUTTON(pins[mso_pkg::P_RBTN]),
		.SECURE_MODE(pins[mso_pkg::P_SECURE]),
		.WDOG_EXPIRE(pins[mso_pkg::P_WDOG]), .DIAG_INTERRUPT_OUT(dg),
		.SUPPLY_ON_REQUEST(sup), .SMI_OUT(smi), .SCI_OUT(sc),
		.SYS_HRST_OUT(hr), .CPU_PG_KILL(pg), .CPU_STOPCLK(st),
		.CLKGEN_DEFAULT(cd), .COOLING_ALARM_LED(co), .POWER_ALARM_LED(pl),
		.SPEAKER(sp), .FLOPPY_WP(fw), .VIDEO_BLANK(vb));
	// ==========================================================
	// verdict and end of run
	task end_sim();
		$display("mismatches %0d comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// one transfer; request held until waitrequest is seen low at an edge
	task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		@(posedge CLK);
		adr <= a;
		wd <= d;
		wr_w <= w;
		rd_w <= !w;
		for (i = 0; i < 64; i++) begin
			@(posedge CLK);
			if (wq === 1'b0) begin
				q = rdd;
				break;
			end
		end
		wr_w <= 1'b0;
		rd_w <= 1'b0;
		if (i == 64) begin n_mismatch++; end_sim(); end
	endtask
	function logic sig(input int s);
		case (s)
			0: return dg;
			1: return sup;
			2: return hr;
			default: return smi;
		endcase
	endfunction
	// bounded wait; n is the number of cycles it took
	task wt(input int s, input logic v, input int lim);
		for (n = 0; n < lim; n++) begin
			@(negedge CLK);
			if (sig(s) === v) break;
		end
		if (n == lim) begin
			n_mismatch++;
			$display("CHECK FAILED wait %0d expected %b seen timeout", s, v);
			end_sim();
		end
	endtask
	task pin(input int p, input logic v);
		@(posedge CLK);
		pm.set_pin(p, v);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		fb = '{mso_pkg::C_SMI, mso_pkg::C_SCI, mso_pkg::C_CLKDEF,
			mso_pkg::C_COOL, mso_pkg::C_PWRLED, mso_pkg::C_SPEAKER,
			mso_pkg::C_FLOPPY, mso_pkg::C_VBLANK, mso_pkg::C_PGKILL,
			mso_pkg::C_PGKILL + 1, mso_pkg::C_STOPCLK, mso_pkg::C_STOPCLK + 1};
		repeat (3) @(posedge CLK);
		SRST <= 1'b0;
		bus(0, mso_pkg::REG_CTRL, 0);
		`CHK("ctrl reset", mso_pkg::CTRL_RST, q)
		`CHK("supply reset", 1'b0, sup)
		// each control bit other than supply that has an output pin reaches exactly its own output
		for (int k = 0; k < 12; k++) begin
			bus(1, mso_pkg::REG_CTRL, 32'h1 << fb[k]);
			bus(0, mso_pkg::REG_CTRL, 0);
			`CHK("ctrl rb", 32'h1 << fb[k], q)
			`CHK("outs", 12'h1 << k, {st, pg, vb, fw, sp, pl, co, cd, sc, smi})
		end
		$display("test ctrl done");
		pin(mso_pkg::P_FPDIAG, 1);
		wt(0, 1, 20);
		pin(mso_pkg::P_FPDIAG, 0);
		wt(0, 0, 20);
		bus(1, mso_pkg::REG_CMD, 32'h1 << mso_pkg::K_DIAG);
		wt(0, 1, 20);
		wt(0, 0, 30 * T);
		`CHK("diag len", 1'b1, n >= 9 * T && n <= 11 * T + 8)
		$display("test diag done");
		bus(1, mso_pkg::REG_CTRL, 32'h1 << mso_pkg::C_COOL);
		bus(1, mso_pkg::REG_CMD, 32'h1 << mso_pkg::K_HRST);
		wt(2, 1, 20);
		bus(0, mso_pkg::REG_CTRL, 0);
		`CHK("ctrl in hrst", 32'h1 << mso_pkg::C_COOL, q)
		wt(2, 0, 120 * T);
		`CHK("cool kept", 1'b1, co)
		$display("test hrst done");
		bus(1, mso_pkg::REG_CTRL, 32'h1 << mso_pkg::C_SUPPLY);
		wt(1, 1, 20);
		bus(1, mso_pkg::REG_CYCLE, 3);
		bus(1, mso_pkg::REG_CMD, 32'h1 << mso_pkg::K_CYCLE);
		wt(1, 0, 20);
		// off time is counted from the fall while the repeat goes in
		fork
			bus(1, mso_pkg::REG_CMD, 32'h1 << mso_pkg::K_CYCLE);
			wt(1, 1, 10 * T);
		join
		`CHK("off time", 1'b1, n >= 2 * T && n <= 4 * T + 8)
		$display("test cycle done");
		pin(mso_pkg::P_SECURE, 1);
		pin(mso_pkg::P_PBTN, 1);
		repeat (4 * T) @(posedge CLK);
		pin(mso_pkg::P_PBTN, 0);
		repeat (4 * T) @(negedge CLK);
		`CHK("secure pwr", 1'b1, sup)
		pin(mso_pkg::P_SECURE, 0);
		bus(1, mso_pkg::REG_CTRL, 32'h1 << mso_pkg::C_LOCKOUT | 32'h1);
		pin(mso_pkg::P_PBTN, 1);
		pin(mso_pkg::P_RBTN, 1);
		repeat (4 * T) @(posedge CLK);
		pin(mso_pkg::P_PBTN, 0);
		pin(mso_pkg::P_RBTN, 0);
		repeat (4 * T) @(negedge CLK);
		`CHK("lock", 2'b10, {sup, hr})
		$display("test lockout done");
		bus(1, mso_pkg::REG_CTRL, 32'h1 << mso_pkg::C_SMIWD | 32'h1);
		pin(mso_pkg::P_WDOG, 1);
		pin(mso_pkg::P_WDOG, 0);
		wt(3, 1, 20);
		bus(1, mso_pkg::REG_CMD, 32'h1 << mso_pkg::K_SMICLR);
		wt(3, 0, 20);
		bus(0, 3'h5, 0);
		`CHK("unmapped", 32'h0, q)
		bus(1, 3'h6, 32'hFFFFFFFF);
		bus(0, mso_pkg::REG_CTRL, 0);
		`CHK("ctrl kept", 32'h1 << mso_pkg::C_SMIWD | 32'h1, q)
		bus(0, mso_pkg::REG_STATUS, 0);
		`CHK("status", 32'h1 << mso_pkg::S_SUPPLY, q)
		$display("test smi done");
		end_sim();
	end
endmodule
